// ==== src/dprc_defs.vh ====
// Shared constants of the digital ratio control block.
// Summary of operation
// - Divide reference by two-bit divider select.
// - Hybrid mode measures reference against synthesized output.
// - Convert ratio to internal clock relative value.
// - Three-bit select sets minimum loop bandwidth.
// - Jitter below corner passes, above attenuated.
// - Wide bandwidth while acquiring, minimum once locked.
// - Ratios are 32-bit unsigned fixed point.
// - Ratio format is 12 integer, 20 fraction.
// - Four ratios held in one-time storage.
// - Mode pins select the active ratio.
// - Internal dividers compensated automatically.
// - N from stored ratio or loop output.
// - Pin code picks modal set; globals shared.
`ifndef DPRC_DEFS_VH
`define DPRC_DEFS_VH

// Ratio word layout, 12.20 unsigned.
`define DPRC_RATIO_W 32
`define DPRC_FRAC_BITS 20
`define DPRC_INT_MSB 31
`define DPRC_INT_LSB 20
// Number of stored ratio slots and slot address width.
`define DPRC_SLOTS 4
`define DPRC_SLOT_W 2
// Reset value of the frequency word.
`define DPRC_FRAC_N_RST 32'h0000_0000
// Measurement window in internal clock ticks, as a power of two.
`define DPRC_WIN_BITS 12
// Edge counter width per window.
`define DPRC_CNT_W 16
// Loop gain shifts: acquisition and locked base.
`define DPRC_ACQ_SHIFT 6'h0C
`define DPRC_LOCK_SHIFT_BASE 6'h0D
// Highest bandwidth code, 128 Hz.
`define DPRC_BW_MAX 3'h7
// Lock tolerance on the scaled error, two output edges.
`define DPRC_LOCK_TOL 50'h0_0000_0020_0000
// Consecutive good windows counted before lock; the next good window declares it.
`define DPRC_LOCK_WINDOWS 3'h4

`endif

// ==== src/dprc_pin_sync.v ====
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module dprc_pin_sync #(
  parameter W = 1
) (
  input wire mclk_i,
  input wire nrst_i,
  input wire clk_en_i,
  input wire [W-1:0] pin_i,
  output reg [W-1:0] level_o
);

  // Synchroniser stages; stage one feeds only stage two.
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  integer i;

  // A bit's new level counts only once stages two and three agree.
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
      s3_reg <= {W{1'b0}};
      level_o <= {W{1'b0}};
    end else if (clk_en_i) begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_reg[i] == s3_reg[i]) begin
          level_o[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule // dprc_pin_sync

// ==== src/dprc_ratio_ctrl.v ====
// Top of the ratio control: divider, ratio selection and digital loop.
`timescale 1ns/1ps
`include "dprc_defs.vh"
module dprc_ratio_ctrl (
  input wire mclk_i,
  input wire nrst_i,
  input wire clk_en_i,
  // Global settings, fixed for every pin code.
  input wire [1:0] reference_divider_select_i,
  input wire [2:0] min_loop_bandwidth_select_i,
  // Programming strap and write port for the one-time store.
  input wire prog_mode_i,
  input wire prog_we_i,
  input wire [`DPRC_SLOT_W-1:0] prog_addr_i,
  input wire [`DPRC_RATIO_W-1:0] prog_ratio_i,
  input wire prog_hybrid_i,
  // Pins from outside the clock domain.
  input wire [1:0] mode_select_i,
  input wire freq_ref_i,
  input wire synth_out_i,
  // Results.
  output reg internal_timing_clock_en_o,
  output reg [`DPRC_RATIO_W-1:0] frac_n_o,
  output reg locked_o,
  output reg wide_bw_o,
  output reg hybrid_active_o,
  output reg [`DPRC_SLOT_W-1:0] active_slot_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Unsigned ratio times an edge count; never sign-extended.
  function [47:0] mul_ratio;
    input [31:0] ratio;
    input [15:0] count;
    begin
      mul_ratio = ratio * count;
    end
  endfunction

  // Saturating increment of an edge counter.
  function [15:0] sat_inc;
    input [15:0] value;
    begin
      if (value == 16'hFFFF) begin
        sat_inc = value;
      end else begin
        sat_inc = value + 16'h0001;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  // Loop phases.
  localparam PH_SEED = 1'b0;
  localparam PH_TRACK = 1'b1;

  // Synchronised pin levels.
  wire [1:0] mode_lvl;
  wire ref_lvl;
  wire syn_lvl;
  // Stored ratio and modal source for the active slot.
  wire [31:0] ratio_q;
  wire hybrid_q;
  // Strap captured after reset release; opens programming.
  reg prog_open_reg;
  reg strap_done_reg;
  // Reference divider counter and tick.
  reg [2:0] div_cnt_reg;
  reg sys_tick_reg;
  // Previous levels for edge detection.
  reg ref_prev_reg;
  reg syn_prev_reg;
  // Window counter and per-window edge counts.
  reg [`DPRC_WIN_BITS-1:0] win_cnt_reg;
  reg [15:0] ref_cnt_reg;
  reg [15:0] syn_cnt_reg;
  // Loop state.
  reg phase_reg;
  reg [2:0] good_cnt_reg;
  reg [1:0] slot_reg;
  reg restart_reg;
  // Combinational loop arithmetic.
  reg [47:0] prod;
  reg signed [49:0] err;
  reg signed [49:0] corr;
  reg signed [49:0] sum;
  reg [49:0] err_mag;
  reg [5:0] shift;
  reg [31:0] seed;
  reg [31:0] frac_next;
  reg err_ok;
  wire ref_edge;
  wire syn_edge;
  wire win_end;
  wire [2:0] div_last;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and the ratio store.

  // Mode pins pass the three-stage filter before selecting a slot.
  dprc_pin_sync #(.W(2)) u_mode_sync (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .clk_en_i(clk_en_i),
    .pin_i(mode_select_i),
    .level_o(mode_lvl)
  );

  // Frequency reference and synthesized feedback are both pins.
  dprc_pin_sync #(.W(2)) u_clk_sync (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .clk_en_i(clk_en_i),
    .pin_i({freq_ref_i, synth_out_i}),
    .level_o({ref_lvl, syn_lvl})
  );

  dprc_ratio_store u_store (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .clk_en_i(clk_en_i),
    .prog_open_i(prog_open_reg),
    .prog_we_i(prog_we_i),
    .prog_addr_i(prog_addr_i),
    .prog_ratio_i(prog_ratio_i),
    .prog_hybrid_i(prog_hybrid_i),
    .rd_addr_i(mode_lvl),
    .rd_ratio_o(ratio_q),
    .rd_hybrid_o(hybrid_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Programming strap.

  // store sealed at runtime when strapped low
  // The strap is caught on the first enabled edge after reset, so a later
  // change of the pin cannot reopen the store while the part runs.
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      prog_open_reg <= 1'b0;
      strap_done_reg <= 1'b0;
    end else if (clk_en_i && !strap_done_reg) begin
      prog_open_reg <= prog_mode_i;
      strap_done_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference divider.

  // Divide ratios are 1, 2, 4 and 8; the count wraps at the last value.
  assign div_last = (3'h1 << reference_divider_select_i) - 3'h1;

  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      div_cnt_reg <= 3'h0;
      sys_tick_reg <= 1'b0;
      internal_timing_clock_en_o <= 1'b0;
    end else if (clk_en_i) begin
      if (div_cnt_reg >= div_last) begin
        div_cnt_reg <= 3'h0;
        sys_tick_reg <= 1'b1;
      end else begin
        div_cnt_reg <= div_cnt_reg + 3'h1;
        sys_tick_reg <= 1'b0;
      end
      internal_timing_clock_en_o <= (div_cnt_reg >= div_last);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge counting over a window of internal clock ticks.

  assign ref_edge = ref_lvl & ~ref_prev_reg;
  assign syn_edge = syn_lvl & ~syn_prev_reg;
  assign win_end = sys_tick_reg && (win_cnt_reg == {`DPRC_WIN_BITS{1'b1}});

  // count reference and output
  // Edges are counted on the fast clock; the window length is in divided
  // ticks so the count scales with the divider, which the seed undoes.
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      ref_prev_reg <= 1'b0;
      syn_prev_reg <= 1'b0;
      win_cnt_reg <= 12'h000;
      ref_cnt_reg <= 16'h0000;
      syn_cnt_reg <= 16'h0000;
    end else if (clk_en_i) begin
      ref_prev_reg <= ref_lvl;
      syn_prev_reg <= syn_lvl;
      if (restart_reg || win_end) begin
        // A fresh window starts after each result or a slot change.
        win_cnt_reg <= 12'h000;
        ref_cnt_reg <= 16'h0000;
        syn_cnt_reg <= 16'h0000;
      end else begin
        if (sys_tick_reg) begin
          win_cnt_reg <= win_cnt_reg + 12'h001;
        end
        if (ref_edge) begin
          ref_cnt_reg <= sat_inc(ref_cnt_reg);
        end
        if (syn_edge) begin
          syn_cnt_reg <= sat_inc(syn_cnt_reg);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loop arithmetic.

  // error scaled by fraction bits
  // The error compares output edges, scaled by 2^20, with ratio times
  // reference edges, so a zero error means the 12.20 ratio is met.
  always @* begin
    prod = mul_ratio(ratio_q, ref_cnt_reg);
    err = $signed({14'h0000, syn_cnt_reg, 20'h0_0000}) - $signed({2'h0, prod});
    err_mag = err[49] ? (50'h0 - err) : err;
    err_ok = (err_mag < `DPRC_LOCK_TOL);
    if (locked_o) begin
      shift = `DPRC_LOCK_SHIFT_BASE + {3'h0, `DPRC_BW_MAX - min_loop_bandwidth_select_i};
    end else begin
      shift = `DPRC_ACQ_SHIFT;
    end
    // integrating loop filter
    // The shift sets the corner: slow wander follows the input, faster
    // jitter is averaged out over many windows.
    corr = err >>> shift;
    sum = $signed({18'h0_0000, frac_n_o}) + corr;
    if (sum[49]) begin
      frac_next = 32'h0000_0000;
    end else if (|sum[48:32]) begin
      frac_next = 32'hFFFF_FFFF;
    end else begin
      frac_next = sum[31:0];
    end
    // divider compensated in seed
    // Seed = ratio times reference edges per window, over the window
    // length and the divide ratio; saturates rather than wraps.
    if (|prod[47:44]) begin
      seed = 32'hFFFF_FFFF;
    end else begin
      seed = prod[43:12] >> reference_divider_select_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot selection and loop control.

  // N source per modal set
  // The store is addressed by the agreed pin code, so on the switch edge it
  // already reads the new slot and the restart step latches the new source
  // bit; lock drops and the loop reseeds. Stored values are only read here.
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      slot_reg <= 2'h0;
      restart_reg <= 1'b1;
      phase_reg <= PH_SEED;
      good_cnt_reg <= 3'h0;
      frac_n_o <= `DPRC_FRAC_N_RST;
      locked_o <= 1'b0;
      wide_bw_o <= 1'b1;
      hybrid_active_o <= 1'b0;
      active_slot_o <= 2'h0;
    end else if (clk_en_i) begin
      wide_bw_o <= ~locked_o;
      active_slot_o <= slot_reg;
      if (mode_lvl != slot_reg) begin
        // New pin code: switch slot and drop lock; N holds until the next window.
        slot_reg <= mode_lvl;
        restart_reg <= 1'b1;
        phase_reg <= PH_SEED;
        good_cnt_reg <= 3'h0;
        locked_o <= 1'b0;
      end else if (restart_reg) begin
        restart_reg <= 1'b0;
        hybrid_active_o <= hybrid_q;
      end else if (win_end) begin
        if (!hybrid_active_o) begin
          // Synthesizer mode: the stored ratio goes out unchanged.
          frac_n_o <= ratio_q;
          if (good_cnt_reg == `DPRC_LOCK_WINDOWS) begin
            locked_o <= 1'b1;
          end else begin
            good_cnt_reg <= good_cnt_reg + 3'h1;
          end
        end else if (ref_cnt_reg == 16'h0000) begin
          // No reference edges: hold N and fall back to acquisition.
          phase_reg <= PH_SEED;
          good_cnt_reg <= 3'h0;
          locked_o <= 1'b0;
        end else if (phase_reg == PH_SEED) begin
          frac_n_o <= seed;
          phase_reg <= PH_TRACK;
        end else begin
          frac_n_o <= frac_next;
          // Lock needs several good windows in a row; one bad one clears it.
          if (!err_ok) begin
            good_cnt_reg <= 3'h0;
            locked_o <= 1'b0;
          end else if (good_cnt_reg == `DPRC_LOCK_WINDOWS) begin
            locked_o <= 1'b1;
          end else begin
            good_cnt_reg <= good_cnt_reg + 3'h1;
          end
        end
      end
    end
  end

endmodule // dprc_ratio_ctrl

// ==== src/dprc_ratio_store.v ====
// One-time-programmable store for four ratios and their modal source bits.
`timescale 1ns/1ps
`include "dprc_defs.vh"
module dprc_ratio_store (
  input wire mclk_i,
  input wire nrst_i,
  input wire clk_en_i,
  input wire prog_open_i,
  input wire prog_we_i,
  input wire [`DPRC_SLOT_W-1:0] prog_addr_i,
  input wire [`DPRC_RATIO_W-1:0] prog_ratio_i,
  input wire prog_hybrid_i,
  input wire [`DPRC_SLOT_W-1:0] rd_addr_i,
  output reg [`DPRC_RATIO_W-1:0] rd_ratio_o,
  output reg rd_hybrid_o
);

  // Ratio words, one per slot, with the modal source bit.
  reg [`DPRC_RATIO_W-1:0] ratio_mem [0:`DPRC_SLOTS-1];
  reg [`DPRC_SLOTS-1:0] hybrid_mem;
  // Fuse bits: a slot once written cannot change again until reset clears the fuses.
  reg [`DPRC_SLOTS-1:0] fused_reg;

  // one-time slot write
  // Fuses model the one-time cells; the contents survive reset as real cells do.
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      rd_ratio_o <= `DPRC_FRAC_N_RST;
      rd_hybrid_o <= 1'b0;
    end else if (clk_en_i) begin
      if (prog_open_i && prog_we_i && !fused_reg[prog_addr_i]) begin
        ratio_mem[prog_addr_i] <= prog_ratio_i;
        hybrid_mem[prog_addr_i] <= prog_hybrid_i;
      end
      rd_ratio_o <= ratio_mem[rd_addr_i];
      rd_hybrid_o <= hybrid_mem[rd_addr_i];
    end
  end

  // Fuse state is cleared only by reset of the model, standing for a blank part.
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      fused_reg <= 4'h0;
    end else if (clk_en_i && prog_open_i && prog_we_i) begin
      fused_reg[prog_addr_i] <= 1'b1;
    end
  end

endmodule // dprc_ratio_store

// ==== testbench/dprc_clk_src.sv ====
// Far-side model: frequency reference and synthesized output sources.
`timescale 1ns/1ps
module dprc_clk_src (
  input wire mclk_i,
  input wire [7:0] half_i,
  output reg freq_ref_o,
  output reg synth_out_o
);
  // Half-period counter; the output edge sits mid-period so neither source aligns.
  reg [7:0] cnt;
  initial begin
    cnt = 8'h01;
    freq_ref_o = 1'b0;
    synth_out_o = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // rates kept equal
  // Both run at one rate, slower than a quarter of mclk, so the loop sees no error.
  always @(posedge mclk_i) begin
    cnt <= (cnt >= half_i) ? 8'h01 : cnt + 8'h01;
    if (cnt >= half_i) begin
      freq_ref_o <= ~freq_ref_o;
    end
    if (cnt == (half_i >> 1)) begin
      synth_out_o <= ~synth_out_o;
    end
  end
endmodule // dprc_clk_src

// ==== testbench/dprc_ratio_ctrl_assertions.sv ====
// Port checker of the ratio control top.
`timescale 1ns/1ps
`include "dprc_defs.vh"
module dprc_checker (
  input wire mclk_i,
  input wire nrst_i,
  input wire clk_en_i,
  input wire [1:0] reference_divider_select_i,
  input wire [1:0] mode_select_i,
  input wire internal_timing_clock_en_o,
  input wire [`DPRC_RATIO_W-1:0] frac_n_o,
  input wire locked_o,
  input wire wide_bw_o,
  input wire hybrid_active_o,
  input wire [`DPRC_SLOT_W-1:0] active_slot_o
);
  // Cycles spent unlocked, saturating; lock needs several whole windows.
  reg [15:0] unl_cnt;
  always @(posedge mclk_i) begin
    if (!nrst_i || locked_o) begin
      unl_cnt <= 16'h0000;
    end else if (unl_cnt != 16'hFFFF) begin
      unl_cnt <= unl_cnt + 16'h0001;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  //////////////////////////////////////////////////////////////////////////
  property p_bw_lock;
    $past(clk_en_i) && $past(nrst_i) |-> wide_bw_o == !$past(locked_o);
  endproperty
  a_bw_lock: assert property (p_bw_lock) else $error("wide flag not inverse of lock");
  property p_div_gap;
    internal_timing_clock_en_o && clk_en_i && reference_divider_select_i != 2'h0 &&
      $stable(reference_divider_select_i) |=> !internal_timing_clock_en_o;
  endproperty
  a_div_gap: assert property (p_div_gap) else $error("tick pulse too long");
  property p_div_two;
    (internal_timing_clock_en_o && clk_en_i && reference_divider_select_i == 2'h1 &&
      $stable(reference_divider_select_i)) ##1 (clk_en_i && reference_divider_select_i == 2'h1)
      |=> internal_timing_clock_en_o;
  endproperty
  a_div_two: assert property (p_div_two) else $error("divide by two period wrong");
  property p_slot;
    $changed(mode_select_i) ##1 ($stable(mode_select_i) && clk_en_i)[*6]
      |-> active_slot_o == mode_select_i;
  endproperty
  a_slot: assert property (p_slot) else $error("slot does not follow pins");
  property p_switch_unlock;
    $changed(active_slot_o) |-> ##[0:1] !locked_o;
  endproperty
  a_switch_unlock: assert property (p_switch_unlock) else $error("lock kept on switch");
  property p_synth_hold;
    locked_o && !hybrid_active_o |-> $stable(frac_n_o);
  endproperty
  a_synth_hold: assert property (p_synth_hold) else $error("static word moved");
  property p_lock_time;
    $rose(locked_o) |-> unl_cnt >= 16'h4000;
  endproperty
  a_lock_time: assert property (p_lock_time) else $error("lock declared too early");
  property p_freeze;
    !clk_en_i |=> $stable(frac_n_o) && $stable(active_slot_o) && $stable(locked_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");
  c_lock: cover property ($rose(locked_o));
  c_slot: cover property ($changed(active_slot_o));
  c_hybrid: cover property ($rose(hybrid_active_o));
endmodule // dprc_checker
bind dprc_ratio_ctrl dprc_checker dprc_checker_i (.mclk_i(mclk_i), .nrst_i(nrst_i),
  .clk_en_i(clk_en_i), .reference_divider_select_i(reference_divider_select_i),
  .mode_select_i(mode_select_i), .internal_timing_clock_en_o(internal_timing_clock_en_o),
  .frac_n_o(frac_n_o), .locked_o(locked_o), .wide_bw_o(wide_bw_o),
  .hybrid_active_o(hybrid_active_o), .active_slot_o(active_slot_o));

// ==== testbench/dprc_ratio_ctrl_tb_top.sv ====
// Self-checking bench of the ratio control top.
`timescale 1ns/1ps
`include "dprc_defs.vh"
module dprc_ratio_ctrl_tb_top;
  reg mclk_i, nrst_i, clk_en_i, prog_mode, prog_we, prog_hybrid;
  reg [1:0] div_sel, mode_sel, prog_addr;
  reg [2:0] bw_sel;
  reg [31:0] prog_ratio;
  wire freq_ref, synth_out, tick, locked, wide_bw, hybrid;
  wire [1:0] slot;
  wire [31:0] frac_n;
  integer failures, compares, seed, i, n;
  reg [31:0] r [0:3];
  // Expected values and which output each one belongs to.
  reg [31:0] exp_q [$];
  reg [2:0] sel_q [$];
  reg [31:0] e, a;
  reg [2:0] c;
  reg [7:0] gap_cnt, gap_last;
  event chk_ev;
  dprc_clk_src dprc_clk_src_i (.mclk_i(mclk_i), .half_i(8'h05), .freq_ref_o(freq_ref),
    .synth_out_o(synth_out));
  dprc_ratio_ctrl dprc_ratio_ctrl_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i),
    .reference_divider_select_i(div_sel), .min_loop_bandwidth_select_i(bw_sel),
    .prog_mode_i(prog_mode), .prog_we_i(prog_we), .prog_addr_i(prog_addr),
    .prog_ratio_i(prog_ratio), .prog_hybrid_i(prog_hybrid), .mode_select_i(mode_sel),
    .freq_ref_i(freq_ref), .synth_out_i(synth_out), .internal_timing_clock_en_o(tick),
    .frac_n_o(frac_n), .locked_o(locked), .wide_bw_o(wide_bw), .hybrid_active_o(hybrid),
    .active_slot_o(slot));
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  // Output view by code; code 6 asks whether the loop word sits in its seeded band.
  function [31:0] pick(input [2:0] k);
    case (k)
      3'h0: pick = frac_n;
      3'h1: pick = {31'h0, locked};
      3'h2: pick = {31'h0, wide_bw};
      3'h3: pick = {30'h0, slot};
      3'h4: pick = {31'h0, hybrid};
      3'h5: pick = {24'h00, gap_last};
      default: pick = {31'h0, frac_n > 32'h0001_8000 && frac_n < 32'h0001_B000};
    endcase
  endfunction
  // Tick spacing seen at the outputs, in mclk cycles.
  always @(negedge mclk_i) begin
    if (tick === 1'b1) begin
      gap_last <= gap_cnt;
      gap_cnt <= 8'h01;
    end else begin
      gap_cnt <= gap_cnt + 8'h01;
    end
  end
  // Watcher: takes the oldest note whenever a result is announced.
  initial forever begin
    @(chk_ev);
    e = exp_q.pop_front();
    c = sel_q.pop_front();
    a = pick(c);
    compares = compares + 1;
    if (a !== e) begin
      failures = failures + 1;
      $display("ERROR output %0d expected %h seen %h", c, e, a);
    end
  end
  task note(input [2:0] k, input [31:0] v);
    exp_q.push_back(v);
    sel_q.push_back(k);
    -> chk_ev;
    #1;
  endtask
  task cyc(input integer k);
    repeat (k) @(negedge mclk_i);
  endtask
  // Bounded wait; running out counts as a mismatch and ends the run.
  task wait_for(input [2:0] k, input [31:0] v, input integer lim);
    n = 0;
    while (pick(k) !== v && n < lim) begin
      cyc(1);
      n = n + 1;
    end
    if (n >= lim) begin
      failures = failures + 1;
      $display("ERROR wait on output %0d expected %h seen %h", k, v, pick(k));
      results;
    end
  endtask
  // One store write; the strobe drops for a cycle so writes never merge.
  task wr(input [1:0] ad, input [31:0] v, input h);
    prog_we = 1'b1;
    prog_addr = ad;
    prog_ratio = v;
    prog_hybrid = h;
    cyc(1);
    prog_we = 1'b0;
    cyc(1);
  endtask
  task results;
    $display("Comparisons %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    seed = 35;
    failures = 0;
    compares = 0;
    {nrst_i, prog_we, prog_hybrid, div_sel, mode_sel, prog_addr, prog_ratio} = 0;
    {clk_en_i, prog_mode} = 2'b11;
    bw_sel = $random(seed);
    gap_cnt = 8'h00;
    gap_last = 8'h00;
    cyc(2);
    note(0, 32'h0000_0000);
    note(2, 32'h0000_0001);
    nrst_i = 1'b1;
    cyc(2);
    for (i = 0; i < 3; i = i + 1) begin
      r[i] = $random(seed);
      wr(i[1:0], r[i], 1'b0);
    end
    r[3] = 32'h0010_0000;
    wr(2'h3, r[3], 1'b1);
    wr(2'h1, ~r[1], 1'b1);
    for (i = 3; i >= 0; i = i - 1) begin
      div_sel = i[1:0];
      cyc(24);
      note(5, 32'h0000_0001 << i);
    end
    wait_for(1, 32'h0000_0001, 7 * 4096);
    // The wide flag follows lock one cycle later.
    cyc(1);
    note(0, r[0]);
    note(2, 32'h0000_0000);
    clk_en_i = 1'b0;
    cyc(12);
    note(1, 32'h0000_0001);
    clk_en_i = 1'b1;
    for (i = 1; i < 3; i = i + 1) begin
      mode_sel = i[1:0];
      cyc(7);
      note(3, i);
      note(1, 32'h0000_0000);
      wait_for(0, r[i], 2 * 4096 + 50);
      note(4, 32'h0000_0000);
    end
    mode_sel = 2'h3;
    cyc(8);
    note(3, 32'h0000_0003);
    note(4, 32'h0000_0001);
    wait_for(1, 32'h0000_0001, 9 * 4096);
    cyc(1);
    note(2, 32'h0000_0000);
    note(6, 32'h0000_0001);
    nrst_i = 1'b0;
    cyc(2);
    note(0, 32'h0000_0000);
    note(1, 32'h0000_0000);
    nrst_i = 1'b1;
    cyc(2);
    results;
  end
endmodule // dprc_ratio_ctrl_tb_top
